// file: logic/cos_pkg.sv
// package for the channel offset select block
// assumes one 100 MHz clock domain and an external adc/dac/mux front end
`default_nettype none
package cos_pkg;
  localparam int         CH_GRP_PHOT   = 16;  // photometer first-stage group
  localparam int         CH_GRP_SPEC   = 12;  // spectrometer group
  localparam int         CH_PHOT_TOTAL = 48;  // after second stage
  localparam int         CH_W          = 6;   // channel index width
  localparam int         OFS_W         = 4;   // offset code width
  localparam int         SMP_W         = 16;  // adc word width
  localparam int         GAIN          = 12;  // fixed analogue gain
  localparam logic [3:0] OFS_RESET     = 4'h0;
  localparam logic [3:0] OFS_MAX       = 4'hf;
  localparam int         FIFO_DEPTH    = 16;
  localparam int         FIFO_W        = CH_W + SMP_W;
  typedef enum logic [2:0] {
    COS_IDLE   = 3'b000,
    COS_SETCH  = 3'b001,
    COS_CONV   = 3'b010,
    COS_WAIT   = 3'b011,
    COS_EVAL   = 3'b100,
    COS_OBS    = 3'b101
  } cos_state_e;
endpackage : cos_pkg
`default_nettype wire

// file: logic/cos_fifo.sv
// parameterised synchronous fifo with valid/ready on both sides
// assumes single clock, asynchronous active-low reset
`default_nettype none
module cos_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,    // system clock
  input  wire logic             i_nrst,   // async reset, low
  input  wire logic             i_valid,  // write request
  output logic                  o_ready,  // space available
  input  wire logic [WIDTH-1:0] i_data,   // write word
  output logic                  o_valid,  // word available
  input  wire logic             i_ready,  // reader takes word
  output logic      [WIDTH-1:0] o_data    // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             do_wr;
  logic             do_rd;

  // extra pointer bit separates full from empty
  assign o_ready = (wr_ptr[AW] == rd_ptr[AW])
                || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign o_valid = (wr_ptr != rd_ptr);
  assign do_wr   = i_valid && o_ready;
  assign do_rd   = o_valid && i_ready;
  assign o_data  = mem[rd_ptr[AW-1:0]];

  // storage array
  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= i_data;
    end
  end

  // pointers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : cos_fifo
`default_nettype wire

// file: logic/cos_channel_offset_select.sv
// channel offset select: mux sequencing, per-channel offset search, stream out
// assumes an external adc returns one sample per start pulse, same clock
// Functional notes
// (R1) channels scanned in groups of 16 photometer or 12 spectrometer
// (R2) photometer second stage joins three 16-groups into 48 channels
// (R3) each selected channel gets its own stored offset code
// (R4) offset code is 4-bit unsigned, 0 to 15, one per channel
// (R5) codes set before observation, never changed during observation
// (R6) gain 12 analogue; 16-bit unsigned samples forwarded to processing unit
// (R7) search runs for every channel before each observation; i_obs_run starts observation without a search
// (R8) search starts each channel with code zero
// (R9) increment code until sample bit 15 reads zero
// (R10) if any of bits 13-15 set, keep current code
// (R11) if bits 13-15 zero and code nonzero, decrement once, select
// (R12) result depends only on input level, fully deterministic
// (R13) after each code change wait for a fresh conversion
// (R14) at code 15 with bit 15 still set, select 15
`default_nettype none
module cos_channel_offset_select
  import cos_pkg::*;
(
  input  wire logic             i_clk,       // 100 MHz clock
  input  wire logic             i_nrst,      // async reset, low
  input  wire logic             i_spec_mode, // 1: spectrometer 12 ch
  input  wire logic             i_search,    // pulse: start offset search
  input  wire logic             i_obs_run,   // level: observation active
  output logic                  o_search_busy, // search in progress
  output logic                  o_obs_busy,  // observation scanning
  output logic      [CH_W-1:0]  o_mux_ch,    // selected channel
  output logic      [1:0]       o_mux_grp,   // second-stage group select
  output logic      [OFS_W-1:0] o_dac_code,  // offset dac code
  output logic                  o_adc_start, // conversion start pulse
  input  wire logic             i_adc_done,  // conversion complete
  input  wire logic [SMP_W-1:0] i_adc_data,  // sample word
  output logic                  o_dpu_valid, // sample word available
  input  wire logic             i_dpu_ready, // processing unit accepts
  output logic      [CH_W-1:0]  o_dpu_ch,    // channel of sample
  output logic      [SMP_W-1:0] o_dpu_data   // sample word
);
  cos_state_e       state;
  logic [CH_W-1:0]  ch;
  logic [OFS_W-1:0] code;
  // (R4) one 4-bit code per channel
  logic [OFS_W-1:0] ofs_mem [CH_PHOT_TOTAL];
  logic [SMP_W-1:0] smp;
  logic             in_search;
  logic             fifo_ready;
  logic [CH_W-1:0]  last_ch;

  // last channel index for the active instrument
  // (R1) group size select
  assign last_ch = i_spec_mode ? CH_W'(CH_GRP_SPEC - 1)
                               : CH_W'(CH_PHOT_TOTAL - 1);

  // (R2) first-stage group of 16 from channel index
  assign o_mux_grp = i_spec_mode ? 2'h0 : ch[5:4];
  assign o_mux_ch  = ch;
  // (R3) per-channel code applied as channel selected
  assign o_dac_code = in_search ? code : ofs_mem[ch];
  assign o_search_busy = in_search;
  assign o_obs_busy    = (state != COS_IDLE) && !in_search;

  // sequencer: search and observation share the conversion path
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state       <= COS_IDLE;
      ch          <= '0;
      code        <= OFS_RESET;
      in_search   <= 1'b0;
      smp         <= '0;
      o_adc_start <= 1'b0;
    end else begin
      o_adc_start <= 1'b0;
      unique case (state)
        COS_IDLE: begin
          ch <= '0;
          // (R7) search covers every channel
          if (i_search) begin
            in_search <= 1'b1;
            state     <= COS_SETCH;
          end else if (i_obs_run) begin
            in_search <= 1'b0;
            state     <= COS_CONV;
          end
        end
        COS_SETCH: begin
          // (R8) start search at code zero
          code  <= OFS_RESET;
          state <= COS_CONV;
        end
        COS_CONV: begin
          // (R13) fresh conversion after code change
          o_adc_start <= 1'b1;
          state       <= COS_WAIT;
        end
        COS_WAIT: begin
          if (i_adc_done) begin
            smp   <= i_adc_data;
            state <= in_search ? COS_EVAL : COS_OBS;
          end
        end
        COS_EVAL: begin
          // (R12) decision from sample and code only
          if (smp[SMP_W-1] && code != OFS_MAX) begin
            // (R9) top bit still set: step up
            code  <= code + 1'b1;
            state <= COS_CONV;
          end else begin
            if (ch == last_ch) begin
              in_search <= 1'b0;
              state     <= COS_IDLE;
            end else begin
              ch    <= ch + 1'b1;
              state <= COS_SETCH;
            end
          end
        end
        COS_OBS: begin
          // stall the scan while the fifo is full
          if (fifo_ready) begin
            if (!i_obs_run) begin
              state <= COS_IDLE;
            end else begin
              ch    <= (ch == last_ch) ? '0 : ch + 1'b1;
              state <= COS_CONV;
            end
          end
        end
        default: state <= COS_IDLE;
      endcase
    end
  end

  // per-channel code store, written only at search end of a channel
  // (R5) no write outside search
  always_ff @(posedge i_clk) begin
    if (state == COS_EVAL && !(smp[SMP_W-1] && code != OFS_MAX)) begin
      if (smp[SMP_W-1:SMP_W-3] != 3'h0 || code == OFS_RESET) begin
        // (R10) (R14) keep current code
        ofs_mem[ch] <= code;
      end else begin
        // (R11) back off by one
        ofs_mem[ch] <= code - 1'b1;
      end
    end
  end

  // (R6) sample words to processing unit through fifo
  cos_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_valid (state == COS_OBS),
    .o_ready (fifo_ready),
    .i_data  ({ch, smp}),
    .o_valid (o_dpu_valid),
    .i_ready (i_dpu_ready),
    .o_data  ({o_dpu_ch, o_dpu_data})
  );

  // steps taken on one channel; a search must never step past code 15
  // helper only, read by the bound check below
  logic [4:0] n_inc;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      n_inc <= 5'h0;
    end else if (state == COS_SETCH) begin
      n_inc <= 5'h0;
    end else if (state == COS_EVAL && smp[SMP_W-1] && code != OFS_MAX) begin
      n_inc <= n_inc + 5'h1;
    end
  end

  // (R13) conversion start only from the conv state
  a_start_after_code: assert property (@(posedge i_clk) // (R13)
    disable iff (!i_nrst)
    o_adc_start |-> $past(state) == COS_CONV)
    else $error("adc start without conversion state");

  // (R9) increment follows a set top bit
  a_inc_on_msb: assert property (@(posedge i_clk) // (R9)
    disable iff (!i_nrst)
    (state == COS_EVAL && smp[15] && code != OFS_MAX)
      |=> code == $past(code) + 4'h1)
    else $error("code did not step up");

  // (R8) search channel begins at zero
  a_start_zero: assert property (@(posedge i_clk) // (R8)
    disable iff (!i_nrst)
    state == COS_SETCH |=> code == OFS_RESET)
    else $error("search code not zero");

  // (R11) decrement by one on low sample
  a_back_off: assert property (@(posedge i_clk) // (R11)
    disable iff (!i_nrst)
    (state == COS_EVAL && !smp[15] && smp[15:13] == 3'h0 && code != 4'h0)
      |=> ofs_mem[$past(ch)] == $past(code) - 4'h1)
    else $error("back off wrong");

  // (R10) keep code when high bits present
  a_keep_code: assert property (@(posedge i_clk) // (R10)
    disable iff (!i_nrst)
    (state == COS_EVAL && !smp[15] && smp[14:13] != 2'h0)
      |=> ofs_mem[$past(ch)] == $past(code))
    else $error("code not kept");

  // (R14) saturate at fifteen
  a_sat_fifteen: assert property (@(posedge i_clk) // (R14)
    disable iff (!i_nrst)
    (state == COS_EVAL && smp[15] && code == OFS_MAX)
      |=> ofs_mem[$past(ch)] == OFS_MAX)
    else $error("saturation not selected");

  // (R5) dac code stable within observation channel
  a_obs_stable: assert property (@(posedge i_clk) // (R5)
    disable iff (!i_nrst)
    (o_obs_busy && $stable(ch) && $past(o_obs_busy))
      |-> $stable(o_dac_code))
    else $error("offset changed during observation");

  // (R1) channel never passes group limit
  a_ch_limit: assert property (@(posedge i_clk) // (R1)
    disable iff (!i_nrst)
    (state != COS_IDLE && $stable(i_spec_mode)) |-> ch <= last_ch)
    else $error("channel beyond group");

  // (R13) start pulse lasts a single cycle
  a_start_single: assert property (@(posedge i_clk) // (R13)
    disable iff (!i_nrst)
    o_adc_start |=> !o_adc_start)
    else $error("adc start longer than one cycle");

  // (R13) evaluation only on a fresh sample
  a_eval_after_wait: assert property (@(posedge i_clk) // (R13)
    disable iff (!i_nrst)
    state == COS_EVAL |-> $past(state) == COS_WAIT)
    else $error("evaluation without fresh sample");

  // (R13) every code change is followed by a conversion
  a_code_then_conv: assert property (@(posedge i_clk) // (R13)
    disable iff (!i_nrst)
    !$stable(code) |-> state == COS_CONV)
    else $error("code changed without new conversion");

  // (R9) code only clears or steps up by one
  a_code_step: assert property (@(posedge i_clk) // (R9)
    disable iff (!i_nrst)
    !$stable(code) |-> (code == OFS_RESET || code == $past(code) + 4'h1))
    else $error("code moved by more than one");

  // (R5) stored codes written only while searching
  a_eval_in_search: assert property (@(posedge i_clk) // (R5)
    disable iff (!i_nrst)
    state == COS_EVAL |-> in_search)
    else $error("code store outside search");

  // (R7) search ends in idle
  a_search_end_idle: assert property (@(posedge i_clk) // (R7)
    disable iff (!i_nrst)
    $fell(o_search_busy) |-> state == COS_IDLE)
    else $error("search ended outside idle");

  // (R7) search ends only after the last channel
  a_search_all_ch: assert property (@(posedge i_clk) // (R7)
    disable iff (!i_nrst)
    $fell(o_search_busy) |-> ch == last_ch)
    else $error("search ended before last channel");

  // (R7) search starts at the first channel
  a_search_from_zero: assert property (@(posedge i_clk) // (R7)
    disable iff (!i_nrst)
    $rose(o_search_busy) |-> (ch == '0 && state == COS_SETCH))
    else $error("search did not start at channel zero");

  // (R2) only three first-stage groups exist
  a_grp_limit: assert property (@(posedge i_clk) // (R2)
    disable iff (!i_nrst)
    state != COS_IDLE |-> o_mux_grp != 2'h3)
    else $error("group select out of range");

  // (R6) scan holds its word while the fifo is full
  a_obs_stall: assert property (@(posedge i_clk) // (R6)
    disable iff (!i_nrst)
    (state == COS_OBS && !fifo_ready) |=> state == COS_OBS)
    else $error("sample dropped on full fifo");

  // (R6) sample word captured on conversion done
  a_sample_capture: assert property (@(posedge i_clk) // (R6)
    disable iff (!i_nrst)
    (state == COS_WAIT && i_adc_done) |=> smp == $past(i_adc_data))
    else $error("sample word not captured");

  // (R14) no more than fifteen steps on one channel
  a_step_bound: assert property (@(posedge i_clk) // (R14)
    disable iff (!i_nrst)
    n_inc <= {1'b0, OFS_MAX})
    else $error("search stepped past code fifteen");

  // (R3) dac code steady while a search conversion runs
  a_dac_hold: assert property (@(posedge i_clk) // (R3)
    disable iff (!i_nrst)
    (in_search && state == COS_WAIT) |-> $stable(o_dac_code))
    else $error("dac code moved during conversion");
endmodule : cos_channel_offset_select
`default_nettype wire

// file: verif/cos_dpu_model.sv
// processing unit sink model for the sample word stream
// assumes the bench clock and reset; stalls on request or every third cycle
`default_nettype none
module cos_dpu_model (
  input  wire logic i_clk,   // bench clock
  input  wire logic i_nrst,  // async reset, low
  input  wire logic i_hold,  // bench stall request
  output logic      o_ready  // accepts the head word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph;
  // slow pattern so the fifo sees gaps even when not held
  always @(negedge i_clk or negedge i_nrst) begin
    if (!i_nrst) ph <= 2'h0;
    else ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
  end
  assign o_ready = !i_hold && (ph != 2'h2);
endmodule : cos_dpu_model
`default_nettype wire

// file: verif/cos_channel_offset_select_tb.sv
// bench for the channel offset select block with adc and dac model
// assumes 100 MHz clock; adc answers 4 cycles after each start pulse
`default_nettype none
module cos_channel_offset_select_tb;
  import cos_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 24576;  // dac step in adc counts, arbitrary
  logic i_clk = 1'b0, i_nrst = 1'b0, spec = 1'b0, srch = 1'b0;
  logic obs = 1'b0, hold = 1'b0, done = 1'b0, s_busy, o_busy, start;
  logic dv, rdy;
  logic [CH_W-1:0]  mux_ch, dch;
  logic [1:0]       grp;
  logic [OFS_W-1:0] dac;
  logic [SMP_W-1:0] adc = 16'h0000, smp = 16'h0000, dd;
  int errors = 0, n_checks = 0, cnt = 0;
  always #5 i_clk = ~i_clk;
  cos_channel_offset_select u_cos_channel_offset_select (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_spec_mode(spec), .i_search(srch), .i_obs_run(obs),
    .o_search_busy(s_busy), .o_obs_busy(o_busy), .o_mux_ch(mux_ch),
    .o_mux_grp(grp), .o_dac_code(dac), .o_adc_start(start),
    .i_adc_done(done), .i_adc_data(adc), .o_dpu_valid(dv),
    .i_dpu_ready(rdy), .o_dpu_ch(dch), .o_dpu_data(dd));
  cos_dpu_model u_cos_dpu_model (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_hold(hold), .o_ready(rdy));
  // analogue chain: input level minus code steps, clipped to 16 bits
  function automatic logic [SMP_W-1:0] level(int ch, int c);
    int v;
    v = ch * 20000 + 5000 - c * STEP;
    return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hffff : 16'(v);
  endfunction : level
  // reference search result per channel
  function automatic logic [OFS_W-1:0] pick(int ch);
    int c;
    c = 0;
    while (c < 15 && level(ch, c) >= 16'h8000) c++;
    if (level(ch, c) < 16'h2000 && c != 0) c--;
    return 4'(c);
  endfunction : pick
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // adc model; data line toggles outside the done pulse
  always @(negedge i_clk) begin
    if (cnt == 1) begin
      done <= 1'b1;
      adc <= smp;
    end else begin
      done <= 1'b0;
      adc <= ~adc;
    end
    if (cnt > 0) cnt <= cnt - 1;
    if (start === 1'b1) begin
      smp <= level(mux_ch, dac);
      cnt <= 4;
      check(grp, spec ? 2'h0 : mux_ch[5:4]);
      check(mux_ch < (spec ? 12 : 48), 1'b1);
      if (s_busy === 1'b0) check(dac, pick(mux_ch));
    end
  end
  task automatic t_search(logic mode);
    spec <= mode;
    @(negedge i_clk) srch <= 1'b1;
    @(negedge i_clk) srch <= 1'b0;
    @(negedge i_clk);
    check(s_busy, 1'b1);
    for (int i = 0; i < 20000 && s_busy !== 1'b0; i++) @(negedge i_clk);
    check(s_busy, 1'b0);
    $display("search done, mode %0d", mode);
  endtask : t_search
  // stall first so the fifo fills, then take n words, stop and drain the fifo
  task automatic t_obs(int n, int stall);
    int k, prev;
    k = 0;
    prev = -1;
    hold <= 1'b1;
    obs <= 1'b1;
    repeat (stall) @(negedge i_clk);
    hold <= 1'b0;
    for (int i = 0; i < 20000 && (k < n || o_busy !== 1'b0 || dv !== 1'b0);
         i++) begin
      @(negedge i_clk);
      #1;
      if (dv === 1'b1 && rdy === 1'b1) begin
        check(dd, level(dch, pick(dch)));
        if (prev >= 0) check(dch, (prev + 1) % (spec ? 12 : 48));
        prev = dch;
        k++;
      end
      if (k >= n) obs <= 1'b0;
    end
    check(dv, 1'b0);
    $display("observation done, %0d words", k);
  endtask : t_obs
  initial begin
    #500us;
    errors++;
    $display("watchdog expired");
    wrap_up();
  end
  initial begin
    repeat (20) @(negedge i_clk);
    i_nrst <= 1'b1;
    @(negedge i_clk);
    t_search(1'b0);
    t_obs(60, 400);
    t_search(1'b1);
    t_obs(30, 0);
    // repeated search must give the same codes
    t_search(1'b0);
    t_obs(50, 0);
    wrap_up();
  end
endmodule : cos_channel_offset_select_tb
`default_nettype wire
